// ===== fan_channel_monitor.sv
/*
 * One fan channel: saturating speed reading, counter overflow flag and
 * sticky fault flag against a programmed threshold.
 * Assumes speed_raw is a synchronous count from the speed measurement logic.
 */
`timescale 1ns/100ps
`default_nettype none
module fan_channel_monitor #(
    parameter int READ_W = fan_status_pkg::READ_W,
    parameter int RAW_W = fan_status_pkg::RAW_W
) (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic resetn,
    // Measurement and control
    input wire logic [RAW_W-1:0] speed_raw,
    input wire logic [READ_W-1:0] fault_threshold,
    input wire logic fault_clear,
    // Results
    output logic [READ_W-1:0] speed_reading,
    output logic overflow,
    output logic fault
);
    localparam logic [RAW_W-1:0] MAX_RAW = RAW_W'({READ_W{1'b1}});

    logic [READ_W-1:0] reading_r, reading_nxt;
    logic ovf_r, ovf_nxt;
    logic fault_r, fault_nxt;

    always_comb begin
        ovf_nxt = (speed_raw > MAX_RAW);
        reading_nxt = ovf_nxt ? {READ_W{1'b1}} : speed_raw[READ_W-1:0];
        // Set beats clear so a slow fan seen during a clear is not lost
        if (reading_nxt < fault_threshold) begin
            fault_nxt = 1'b1;
        end else if (fault_clear) begin
            fault_nxt = 1'b0;
        end else begin
            fault_nxt = fault_r;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!resetn) begin
            reading_r <= '0;
            ovf_r <= fan_status_pkg::OVF_RESET;
            fault_r <= fan_status_pkg::FAULT_RESET;
        end else begin
            reading_r <= reading_nxt;
            ovf_r <= ovf_nxt;
            fault_r <= fault_nxt;
        end
    end

    assign speed_reading = reading_r;
    assign overflow = ovf_r;
    assign fault = fault_r;

    property p_ovf_set;
        @(posedge ref_clk) disable iff (!resetn)
        (speed_raw > MAX_RAW) |=> overflow && (speed_reading == {READ_W{1'b1}});
    endproperty
    a_ovf_set: assert property (p_ovf_set) else $error("overflow flag not set");

    property p_ovf_clear;
        @(posedge ref_clk) disable iff (!resetn)
        (speed_raw <= MAX_RAW) |=> !overflow && (speed_reading == $past(speed_raw[READ_W-1:0]));
    endproperty
    a_ovf_clear: assert property (p_ovf_clear) else $error("overflow flag not self cleared");

    property p_fault_set;
        @(posedge ref_clk) disable iff (!resetn)
        (!(speed_raw > MAX_RAW) && (speed_raw[READ_W-1:0] < fault_threshold)) |=> fault;
    endproperty
    a_fault_set: assert property (p_fault_set) else $error("fault flag not set");

    property p_fault_hold;
        @(posedge ref_clk) disable iff (!resetn)
        (fault && !fault_clear) |=> fault;
    endproperty
    a_fault_hold: assert property (p_fault_hold) else $error("fault flag dropped");

    property p_fault_clear;
        @(posedge ref_clk) disable iff (!resetn)
        (fault_clear && ((speed_raw > MAX_RAW)
            || (speed_raw[READ_W-1:0] >= fault_threshold))) |=> !fault;
    endproperty
    a_fault_clear: assert property (p_fault_clear) else $error("fault flag not cleared");

    c_fault_then_clear: cover property (@(posedge ref_clk) disable iff (!resetn)
        fault ##1 fault_clear ##1 !fault);
endmodule
`default_nettype wire

// ===== fan_controller_status_reg.sv
/*
 * Read-only status register of a dual channel fan speed controller.
 * Assumes the analog comparators and open-pin detector deliver synchronous
 * levels, and the configuration logic provides the fault clear control.
 */
`timescale 1ns/100ps
`default_nettype none
// Overview of operation
// - The status register is an 8-bit read-only location whose bits 7 and 6 read zero.
// - Bit 5 reads one while the temperature input is above the full-duty level, else zero.
// - The over-temperature flag has no reset value and follows the input from power-up.
// - Bit 4 or bit 3 goes to one when fan 2 or fan 1 speed exceeds the counter range.
// - Each overflow bit clears itself once that speed is back within the counter range.
// - Bit 2 reads one when the temperature input pin is open.
// - Bit 2 reads zero whenever a sensing network drives the temperature input.
// - A speed below its threshold sets bit 1 or bit 0 and pulls the fault output low.
// - Fault bits stay set until the fault clear control, and are zero after power-on.
module fan_controller_status_reg #(
    parameter int READ_W = fan_status_pkg::READ_W,
    parameter int RAW_W = fan_status_pkg::RAW_W
) (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic resetn,
    // Temperature input condition
    input wire logic over_temp_cond,
    input wire logic temp_input_open_det,
    // Speed measurement
    input wire logic [RAW_W-1:0] speed1_raw,
    input wire logic [RAW_W-1:0] speed2_raw,
    input wire logic [READ_W-1:0] fan1_speed_threshold,
    input wire logic [READ_W-1:0] fan2_speed_threshold,
    input wire logic fan_fault_clear_ctl,
    // Register port
    input wire logic status_rd_en,
    input wire logic status_wr_en,
    input wire logic [fan_status_pkg::STATUS_W-1:0] status_wr_data,
    output logic [fan_status_pkg::STATUS_W-1:0] status_rd_data,
    output logic status_rd_valid,
    // Fan side results
    output logic [READ_W-1:0] fan1_speed_reading,
    output logic [READ_W-1:0] fan2_speed_reading,
    output logic fault_n
);
    localparam int CH = fan_status_pkg::CHANNELS;

    logic [RAW_W-1:0] raw_a [CH];
    logic [READ_W-1:0] thr_a [CH];
    logic [READ_W-1:0] rd_a [CH];
    logic [CH-1:0] ovf_a;
    logic [CH-1:0] fault_a;

    assign raw_a[0] = speed1_raw;
    assign raw_a[1] = speed2_raw;
    assign thr_a[0] = fan1_speed_threshold;
    assign thr_a[1] = fan2_speed_threshold;

    genvar g;
    generate
        for (g = 0; g < CH; g++) begin : g_chan
            fan_channel_monitor #(
                .READ_W(READ_W),
                .RAW_W(RAW_W)
            ) u_mon (
                .ref_clk(ref_clk),
                .resetn(resetn),
                .speed_raw(raw_a[g]),
                .fault_threshold(thr_a[g]),
                .fault_clear(fan_fault_clear_ctl),
                .speed_reading(rd_a[g]),
                .overflow(ovf_a[g]),
                .fault(fault_a[g])
            );
        end
    endgenerate

    assign fan1_speed_reading = rd_a[0];
    assign fan2_speed_reading = rd_a[1];

    // No reset on purpose: the flag is a live comparator image
    logic over_temp_flag_r, over_temp_flag_nxt;
    logic temp_open_r, temp_open_nxt;
    logic fault_n_r, fault_n_nxt;
    logic [fan_status_pkg::STATUS_W-1:0] rd_data_r, rd_data_nxt;
    logic rd_valid_r, rd_valid_nxt;
    fan_status_pkg::status_t live;
    logic wr_unused;

    assign wr_unused = status_wr_en ^ (^status_wr_data);

    always_comb begin
        over_temp_flag_nxt = over_temp_cond;
        temp_open_nxt = temp_input_open_det;
        fault_n_nxt = !(|fault_a);
    end

    always_comb begin
        live.unused = fan_status_pkg::UNUSED_VALUE;
        live.over_temp_flag = over_temp_flag_r;
        live.speed2_counter_overflow = ovf_a[1];
        live.speed1_counter_overflow = ovf_a[0];
        live.temp_input_open_flag = temp_open_r;
        live.fan2_fault_flag = fault_a[1];
        live.fan1_fault_flag = fault_a[0];
        // Writes never reach any flag, only reads sample them
        rd_data_nxt = status_rd_en ? live : rd_data_r;
        rd_valid_nxt = status_rd_en;
    end

    always_ff @(posedge ref_clk) begin
        over_temp_flag_r <= over_temp_flag_nxt;
    end

    always_ff @(posedge ref_clk) begin
        if (!resetn) begin
            temp_open_r <= fan_status_pkg::OPEN_RESET;
            fault_n_r <= 1'b1;
            rd_data_r <= fan_status_pkg::STATUS_RESET;
            rd_valid_r <= 1'b0;
        end else begin
            temp_open_r <= temp_open_nxt;
            fault_n_r <= fault_n_nxt;
            rd_data_r <= rd_data_nxt;
            rd_valid_r <= rd_valid_nxt;
        end
    end

    assign status_rd_data = rd_data_r;
    assign status_rd_valid = rd_valid_r;
    assign fault_n = fault_n_r;

    property p_unused_zero;
        @(posedge ref_clk) disable iff (!resetn)
        status_rd_valid |-> (status_rd_data[7:6] == 2'h0);
    endproperty
    a_unused_zero: assert property (p_unused_zero) else $error("unused bits not zero");

    property p_over_temp;
        @(posedge ref_clk) disable iff (!resetn)
        status_rd_en |=> status_rd_data[fan_status_pkg::BIT_OVER_TEMP] == $past(over_temp_cond, 2);
    endproperty
    a_over_temp: assert property (p_over_temp) else $error("over-temp bit wrong");

    property p_over_temp_live;
        @(posedge ref_clk)
        over_temp_cond |=> over_temp_flag_r;
    endproperty
    a_over_temp_live: assert property (p_over_temp_live) else $error("over-temp not tracked");

    property p_open_set;
        @(posedge ref_clk) disable iff (!resetn)
        temp_input_open_det ##1 status_rd_en |=>
            status_rd_data[fan_status_pkg::BIT_TEMP_OPEN];
    endproperty
    a_open_set: assert property (p_open_set) else $error("open bit not set");

    property p_open_clear;
        @(posedge ref_clk) disable iff (!resetn)
        !temp_input_open_det ##1 status_rd_en |=>
            !status_rd_data[fan_status_pkg::BIT_TEMP_OPEN];
    endproperty
    a_open_clear: assert property (p_open_clear) else $error("open bit not cleared");

    property p_fault_pin;
        @(posedge ref_clk) disable iff (!resetn)
        (|fault_a) |=> !fault_n;
    endproperty
    a_fault_pin: assert property (p_fault_pin) else $error("fault pin not low");

    property p_ovf_read;
        @(posedge ref_clk) disable iff (!resetn)
        status_rd_en |=> status_rd_data[fan_status_pkg::BIT_SPEED2_OVF] == $past(ovf_a[1])
            && status_rd_data[fan_status_pkg::BIT_SPEED1_OVF] == $past(ovf_a[0]);
    endproperty
    a_ovf_read: assert property (p_ovf_read) else $error("overflow bits misplaced");

    property p_write_ignored;
        @(posedge ref_clk) disable iff (!resetn)
        (status_wr_en && !status_rd_en) |=> $stable(status_rd_data) && !status_rd_valid;
    endproperty
    a_write_ignored: assert property (p_write_ignored) else $error("write changed status");

    property p_fault_read;
        @(posedge ref_clk) disable iff (!resetn)
        status_rd_en |=> status_rd_data[1:0] == $past(fault_a);
    endproperty
    a_fault_read: assert property (p_fault_read) else $error("fault bits misplaced");

    c_read_over_temp: cover property (@(posedge ref_clk) disable iff (!resetn)
        status_rd_valid && status_rd_data[fan_status_pkg::BIT_OVER_TEMP]);
    c_read_fault: cover property (@(posedge ref_clk) disable iff (!resetn)
        status_rd_valid && (status_rd_data[1:0] == 2'h3));
    c_write_seen: cover property (@(posedge ref_clk) disable iff (!resetn)
        status_wr_en && wr_unused);
endmodule
`default_nettype wire

// ===== fan_controller_status_reg_tb_top.sv
/*
 * Self-checking bench for the fan controller status register.
 * Assumes the host model in status_host.sv and the shared package.
 */
`timescale 1ns/100ps
`default_nettype none
module fan_controller_status_reg_tb_top;
    logic ref_clk = 1'b0;
    logic resetn = 1'b0;
    logic over_temp_cond = 1'b1;
    logic temp_input_open_det = 1'b0;
    logic fan_fault_clear_ctl = 1'b0;
    logic [15:0] speed1_raw = 16'h0000;
    logic [15:0] speed2_raw = 16'h0000;
    logic [7:0] fan1_speed_threshold = 8'h00;
    logic [7:0] fan2_speed_threshold = 8'h00;
    logic [7:0] fan1_speed_reading;
    logic [7:0] fan2_speed_reading;
    logic fault_n;
    wire logic status_rd_en;
    wire logic status_wr_en;
    wire logic [7:0] status_wr_data;
    wire logic [7:0] status_rd_data;
    wire logic status_rd_valid;
    int err_count = 0;
    int samples_checked = 0;

    always #2 ref_clk = ~ref_clk;

    fan_controller_status_reg u_fan_controller_status_reg (
        .ref_clk(ref_clk), .resetn(resetn), .over_temp_cond(over_temp_cond),
        .temp_input_open_det(temp_input_open_det), .speed1_raw(speed1_raw),
        .speed2_raw(speed2_raw), .fan1_speed_threshold(fan1_speed_threshold),
        .fan2_speed_threshold(fan2_speed_threshold),
        .fan_fault_clear_ctl(fan_fault_clear_ctl), .status_rd_en(status_rd_en),
        .status_wr_en(status_wr_en), .status_wr_data(status_wr_data),
        .status_rd_data(status_rd_data), .status_rd_valid(status_rd_valid),
        .fan1_speed_reading(fan1_speed_reading), .fan2_speed_reading(fan2_speed_reading),
        .fault_n(fault_n));

    status_host u_status_host (
        .ref_clk(ref_clk), .status_rd_en(status_rd_en), .status_wr_en(status_wr_en),
        .status_wr_data(status_wr_data), .status_rd_data(status_rd_data),
        .status_rd_valid(status_rd_valid));

    task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            err_count++;
            $display("[FAIL] %s expected %h seen %h", name, exp, seen);
        end
    endtask
    // Two settle cycles cover the fault flag-then-fault_n latency
    task automatic read_expect(input string name, input logic [7:0] exp);
        logic [7:0] d;
        logic v;
        repeat (2) @(posedge ref_clk);
        u_status_host.read_status(d, v);
        check({name, "_valid"}, {7'h00, v}, 8'h01);
        check(name, d, exp);
    endtask

    task automatic test_reset_over_temp();
        read_expect("over_temp_from_reset", 8'h20);
        check("fault_n_reset", {7'h00, fault_n}, 8'h01);
        over_temp_cond = 1'b0;
        read_expect("over_temp_low", 8'h00);
        over_temp_cond = 1'b1;
        read_expect("over_temp_high", 8'h20);
        over_temp_cond = 1'b0;
    endtask
    task automatic test_write_ignored();
        u_status_host.write_status(8'hFF);
        check("valid_after_write", {7'h00, status_rd_valid}, 8'h00);
        read_expect("after_write", 8'h00);
    endtask
    task automatic test_overflow();
        speed2_raw = 16'h0100;
        read_expect("ovf2", 8'h10);
        speed1_raw = 16'h0100;
        read_expect("ovf_both", 8'h18);
        check("reading1_sat", fan1_speed_reading, 8'hFF);
        check("reading2_sat", fan2_speed_reading, 8'hFF);
        speed1_raw = 16'h00FF;
        speed2_raw = 16'h00FF;
        read_expect("ovf_self_clear", 8'h00);
    endtask
    task automatic test_open();
        temp_input_open_det = 1'b1;
        read_expect("open_set", 8'h04);
        temp_input_open_det = 1'b0;
        read_expect("open_clear", 8'h00);
    endtask
    task automatic test_fault();
        fan1_speed_threshold = 8'h20;
        fan2_speed_threshold = 8'h20;
        speed1_raw = 16'h001F;
        speed2_raw = 16'h0020;
        read_expect("fault1", 8'h01);
        check("fault_n_low", {7'h00, fault_n}, 8'h00);
        check("reading1_live", fan1_speed_reading, 8'h1F);
        check("reading2_live", fan2_speed_reading, 8'h20);
        speed1_raw = 16'h0040;
        speed2_raw = 16'h0010;
        read_expect("fault_sticky", 8'h03);
        speed2_raw = 16'h0040;
        @(posedge ref_clk);
        #1 fan_fault_clear_ctl = 1'b1;
        @(posedge ref_clk);
        #1 fan_fault_clear_ctl = 1'b0;
        read_expect("fault_cleared", 8'h00);
        check("fault_n_high", {7'h00, fault_n}, 8'h01);
    endtask
    // Faults must come back zero after a mid-run reset
    task automatic test_mid_reset();
        speed1_raw = 16'h0010;
        over_temp_cond = 1'b1;
        read_expect("before_reset", 8'h21);
        speed1_raw = 16'h0040;
        resetn = 1'b0;
        repeat (2) @(posedge ref_clk);
        #1 resetn = 1'b1;
        check("fault_n_in_reset", {7'h00, fault_n}, 8'h01);
        read_expect("after_reset", 8'h20);
    endtask

    task automatic end_of_test();
        $display("checks %0d mismatches %0d", samples_checked, err_count);
        if (err_count == 0 && samples_checked > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    // Whole run is under a hundred cycles
    initial begin
        #20000;
        err_count++;
        end_of_test();
    end
    initial begin
        repeat (4) @(posedge ref_clk);
        #1 resetn = 1'b1;
        test_reset_over_temp();
        test_write_ignored();
        test_overflow();
        test_open();
        test_fault();
        test_mid_reset();
        end_of_test();
    end
endmodule
`default_nettype wire

// ===== fan_status_pkg.sv
/*
 * Shared constants and types for the fan controller status register.
 * Assumes nothing beyond a SystemVerilog compiler.
 */
package fan_status_pkg;
    localparam int STATUS_W = 8;
    localparam int CHANNELS = 2;
    localparam int READ_W = 8;
    localparam int RAW_W = 16;
    localparam int BIT_OVER_TEMP = 5;
    localparam int BIT_SPEED2_OVF = 4;
    localparam int BIT_SPEED1_OVF = 3;
    localparam int BIT_TEMP_OPEN = 2;
    localparam int BIT_FAN2_FAULT = 1;
    localparam int BIT_FAN1_FAULT = 0;
    localparam logic [1:0] UNUSED_VALUE = 2'h0;
    localparam logic [STATUS_W-1:0] STATUS_RESET = 8'h00;
    localparam logic FAULT_RESET = 1'b0;
    localparam logic OVF_RESET = 1'b0;
    localparam logic OPEN_RESET = 1'b0;

    typedef struct packed {
        logic [1:0] unused;
        logic over_temp_flag;
        logic speed2_counter_overflow;
        logic speed1_counter_overflow;
        logic temp_input_open_flag;
        logic fan2_fault_flag;
        logic fan1_fault_flag;
    } status_t;
endpackage

// ===== status_host.sv
/*
 * Host model that reads and writes the status register through its strobe port.
 * Assumes one clock, with requests driven just after its rising edge.
 */
`timescale 1ns/100ps
`default_nettype none
module status_host (
    // Clock
    input wire logic ref_clk,
    // Register port
    output logic status_rd_en,
    output logic status_wr_en,
    output logic [fan_status_pkg::STATUS_W-1:0] status_wr_data,
    input wire logic [fan_status_pkg::STATUS_W-1:0] status_rd_data,
    input wire logic status_rd_valid
);
    initial begin
        status_rd_en = 1'b0;
        status_wr_en = 1'b0;
        status_wr_data = 8'h00;
    end
    // One strobe cycle; the answer is registered at the taking edge
    task automatic read_status(output logic [7:0] data, output logic valid);
        @(posedge ref_clk);
        #1 status_rd_en = 1'b1;
        @(posedge ref_clk);
        #1 status_rd_en = 1'b0;
        valid = status_rd_valid;
        data = status_rd_data;
    endtask
    task automatic write_status(input logic [7:0] data);
        @(posedge ref_clk);
        #1 status_wr_en = 1'b1;
        status_wr_data = data;
        @(posedge ref_clk);
        #1 status_wr_en = 1'b0;
        // Released bus shows the inverse, not a stale value
        status_wr_data = ~data;
    endtask
endmodule
`default_nettype wire
